/* pdsc_pkg.sv */
// constants, field layout and types of the power domain status and control
// Behaviour
// - domain status bit 9 reads 1 once the domain power-on reset has completed
// - domain status bit 8 mirrors the domain power-on reset, 1 when released
// - status bits 4-0: 0 off, 1h on, 10h-1Ah while transitioning
// - domain status bit 11 is set while emulation overrode the domain state
// - control bits 23-16 hold wake delays, reset 1Fh, low nibble on-to-good
// - switched domain power-down mode in bits 15-12, reset Fh all on
// - always-on domain power-down mode reads Fh only
// - control bit 9 enables the emulation override interrupt, reset 0
// - switched domain control bit 0 holds next state, 1 on, resets 1
// - always-on next state bit is read/write but never changes the domain
// - config bit 3 shows next state lock; when locked writes do not alter it
// - config bits 2,1,0 show debug tap, ram domain and always-on flags
// - module status bit 17 flags emulation state override of module 14 only
// - module status bit 16 flags emulation reset override of module 14 only
// - module status bit 12 shows whether the module clock is running
// - writing 1 to a go bit moves mismatching states; writing 0 does nothing
// - module state bits 5-0: 0,1h,2h,3h stable, 4h-3Fh transitioning
// - transition status bit reads 1 while domain or its modules transition
package pdsc_pkg;
   // ==========================================================
   // register byte offsets (low twelve address bits)
   localparam logic [11:0] GO_CMD_OFF     = 12'h120;
   localparam logic [11:0] GO_STAT_OFF    = 12'h128;
   localparam logic [11:0] AON_STAT_OFF   = 12'h200;
   localparam logic [11:0] SW_STAT_OFF    = 12'h204;
   localparam logic [11:0] AON_CTL_OFF    = 12'h300;
   localparam logic [11:0] SW_CTL_OFF     = 12'h304;
   localparam logic [11:0] AON_CFG_OFF    = 12'h400;
   localparam logic [11:0] SW_CFG_OFF     = 12'h404;
   localparam logic [11:0] MOD_STAT_BASE  = 12'h800;
   localparam logic [11:0] MOD_STAT_LAST  = 12'h87c;
   // ==========================================================
   // field positions
   localparam int STAT_EMU_BIT     = 11;
   localparam int STAT_DOMAIN_POR_COMPLETE_BIT = 9;
   localparam int STAT_POR_BIT     = 8;
   localparam int CTL_WAKE_LSB     = 16;
   localparam int CTL_MODE_LSB     = 12;
   localparam int CTL_IRQEN_BIT    = 9;
   localparam int CTL_ONE_BIT      = 8;
   localparam int CFG_LOCK_BIT     = 3;
   localparam int CFG_TAP_BIT      = 2;
   localparam int CFG_RAM_BIT      = 1;
   localparam int CFG_AON_BIT      = 0;
   localparam int MOD_EMU_BIT      = 17;
   localparam int MOD_EMULATION_RESET_OVERRIDE_FLAG_BIT   = 16;
   localparam int MOD_CLK_BIT      = 12;
   localparam int CPU_MODULE_IDX   = 14;
   // ==========================================================
   // codes and reset values
   localparam logic [4:0] DOM_OFF       = 5'h00;
   localparam logic [4:0] DOM_ON        = 5'h01;
   localparam logic [4:0] DOM_TR_DOWN   = 5'h10;
   localparam logic [4:0] DOM_TR_ON2G   = 5'h11;
   localparam logic [4:0] DOM_TR_G2ACC  = 5'h12;
   localparam logic [7:0] WAKE_RST      = 8'h1f;
   localparam logic [3:0] MODE_ALL_ON   = 4'hf;
   // ==========================================================
   // timing: settle time of a power-down, rounded up to cycles
   localparam int CLK_PERIOD_PS   = 25000;
   localparam int DOWN_SETTLE_NS  = 100;
   localparam int DOWN_CYCLES     =
      (DOWN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   typedef enum logic [1:0] {
      SQ_IDLE   = 2'b00,
      SQ_DOWN   = 2'b01,
      SQ_ON2G   = 2'b10,
      SQ_G2ACC  = 2'b11
   } pdsc_seq_type;
endpackage

/* pdsc_ctrl.sv */
// apb register block and switched domain sequencer of the power controller
`timescale 1ns/1ps
module pdsc_ctrl #(
   parameter int        NUM_MODULES   = 32,
   parameter bit        SW_LOCKED     = 1'b0,
   parameter bit        AON_HAS_TAP   = 1'b0,
   parameter bit        SW_HAS_TAP    = 1'b0,
   parameter bit        SW_IS_RAM     = 1'b1
) (
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [1:0]                dom_por_n,
   input  wire logic [1:0]                dom_por_done,
   input  wire logic [1:0]                dom_emu_override,
   input  wire logic [1:0]                dom_err_clear,
   input  wire logic                      cpu_emu_override,
   input  wire logic                      cpu_emu_rst_override,
   input  wire logic                      cpu_err_clear,
   input  wire logic                      emulation_override_irq_enable,
   input  wire logic                      emulation_reset_override_irq_enable,
   input  wire logic [NUM_MODULES-1:0]    module_clock_running,
   input  wire logic [NUM_MODULES*6-1:0]  module_state,
   input  wire logic [1:0]                module_busy,
   output logic [1:0]                     module_go,
   output logic                           sw_power_on,
   output logic [3:0]                     power_down_mode,
   output logic [1:0]                     dom_override_irq,
   output logic                           cpu_override_irq
);
   // ==========================================================
   // pin synchronisers: por levels and module clock status
   localparam int SYNC_W = 4 + NUM_MODULES;
   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic [1:0]        por_n_s;
   logic [1:0]        por_done_s;
   logic [NUM_MODULES-1:0] clk_run_s;

   logic [SYNC_W-1:0] sync_in;

   // one process owns both stages, so no bit of a stage has two drivers
   assign sync_in = {module_clock_running, dom_por_done, dom_por_n};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_ff <= {SYNC_W{1'b0}};
         sync2_ff <= {SYNC_W{1'b0}};
      end else begin
         sync1_ff <= sync_in;
         sync2_ff <= sync1_ff;
      end
   end

   assign por_n_s    = sync2_ff[1:0];
   assign por_done_s = sync2_ff[3:2];
   assign clk_run_s  = sync2_ff[SYNC_W-1:4];

   // ==========================================================
   // apb decode
   logic [11:0] addr;
   logic        setup_ph;
   logic        wr_acc;

   assign addr     = paddr[11:0];
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite;
   assign pready   = 1'b1;

   function automatic logic is_mapped(input logic [11:0] a);
      if (a == pdsc_pkg::GO_CMD_OFF || a == pdsc_pkg::GO_STAT_OFF)
         return 1'b1;
      else if (a == pdsc_pkg::AON_STAT_OFF || a == pdsc_pkg::SW_STAT_OFF)
         return 1'b1;
      else if (a == pdsc_pkg::AON_CTL_OFF || a == pdsc_pkg::SW_CTL_OFF)
         return 1'b1;
      else if (a == pdsc_pkg::AON_CFG_OFF || a == pdsc_pkg::SW_CFG_OFF)
         return 1'b1;
      else if (a >= pdsc_pkg::MOD_STAT_BASE &&
               a <= pdsc_pkg::MOD_STAT_LAST && a[1:0] == 2'b00)
         return 1'b1;
      else
         return 1'b0;
   endfunction

   function automatic logic wr_hit(input logic [11:0] a,
                                   input logic [11:0] off,
                                   input logic        acc);
      return acc && (a == off);
   endfunction

   // ==========================================================
   // control registers
   logic [7:0] wake_ff     [2];
   logic [3:0] sw_mode_ff;
   logic [1:0] irq_en_ff;
   logic [1:0] next_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wake_ff[0] <= pdsc_pkg::WAKE_RST;
         wake_ff[1] <= pdsc_pkg::WAKE_RST;
         sw_mode_ff <= pdsc_pkg::MODE_ALL_ON;
         irq_en_ff  <= 2'b00;
         next_ff    <= 2'b11;
      end else begin
         if (wr_hit(addr, pdsc_pkg::AON_CTL_OFF, wr_acc)) begin
            wake_ff[0]   <= pwdata[pdsc_pkg::CTL_WAKE_LSB +: 8];
            irq_en_ff[0] <= pwdata[pdsc_pkg::CTL_IRQEN_BIT];
            // stored for read back only, the domain stays on
            next_ff[0]   <= pwdata[0];
         end
         if (wr_hit(addr, pdsc_pkg::SW_CTL_OFF, wr_acc)) begin
            wake_ff[1]   <= pwdata[pdsc_pkg::CTL_WAKE_LSB +: 8];
            sw_mode_ff   <= pwdata[pdsc_pkg::CTL_MODE_LSB +: 4];
            irq_en_ff[1] <= pwdata[pdsc_pkg::CTL_IRQEN_BIT];
            if (!SW_LOCKED) begin
               next_ff[1] <= pwdata[0];
            end
         end
      end
   end

   // ==========================================================
   // go command: a write of 0 leaves both pulses low
   logic go_sw;

   assign go_sw = wr_hit(addr, pdsc_pkg::GO_CMD_OFF, wr_acc) & pwdata[1];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         module_go <= 2'b00;
      end else if (wr_hit(addr, pdsc_pkg::GO_CMD_OFF, wr_acc)) begin
         module_go <= pwdata[1:0];
      end else begin
         module_go <= 2'b00;
      end
   end

   // ==========================================================
   // switched domain sequencer; a go while a sequence runs is ignored
   pdsc_pkg::pdsc_seq_type seq_ff;
   logic [7:0]             cnt_ff;
   logic [4:0]             dom_state_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seq_ff       <= pdsc_pkg::SQ_IDLE;
         cnt_ff       <= 8'h00;
         dom_state_ff <= pdsc_pkg::DOM_ON;
         sw_power_on  <= 1'b1;
      end else begin
         case (seq_ff)
            pdsc_pkg::SQ_IDLE: begin
               if (go_sw && next_ff[1] != sw_power_on) begin
                  if (next_ff[1]) begin
                     seq_ff       <= pdsc_pkg::SQ_ON2G;
                     cnt_ff       <= {4'h0, wake_ff[1][3:0]};
                     dom_state_ff <= pdsc_pkg::DOM_TR_ON2G;
                     sw_power_on  <= 1'b1;
                  end else begin
                     seq_ff       <= pdsc_pkg::SQ_DOWN;
                     cnt_ff       <= 8'(pdsc_pkg::DOWN_CYCLES - 1);
                     dom_state_ff <= pdsc_pkg::DOM_TR_DOWN;
                  end
               end
            end
            pdsc_pkg::SQ_ON2G: begin
               if (cnt_ff == 8'h00) begin
                  seq_ff       <= pdsc_pkg::SQ_G2ACC;
                  cnt_ff       <= {4'h0, wake_ff[1][7:4]};
                  dom_state_ff <= pdsc_pkg::DOM_TR_G2ACC;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            pdsc_pkg::SQ_G2ACC: begin
               if (cnt_ff == 8'h00) begin
                  seq_ff       <= pdsc_pkg::SQ_IDLE;
                  dom_state_ff <= pdsc_pkg::DOM_ON;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            pdsc_pkg::SQ_DOWN: begin
               if (cnt_ff == 8'h00) begin
                  seq_ff       <= pdsc_pkg::SQ_IDLE;
                  dom_state_ff <= pdsc_pkg::DOM_OFF;
                  sw_power_on  <= 1'b0;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            default: seq_ff <= pdsc_pkg::SQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         power_down_mode <= pdsc_pkg::MODE_ALL_ON;
      end else begin
         power_down_mode <= sw_mode_ff;
      end
   end

   // ==========================================================
   // sticky emulation override flags; the set wins over a clear
   logic [1:0] dom_emu_ff;
   logic       cpu_emu_ff;
   logic       cpu_emulation_reset_override_flag_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dom_emu_ff    <= 2'b00;
         cpu_emu_ff    <= 1'b0;
         cpu_emulation_reset_override_flag_ff <= 1'b0;
      end else begin
         dom_emu_ff    <= dom_emu_override |
                          (dom_emu_ff & ~dom_err_clear);
         cpu_emu_ff    <= cpu_emu_override |
                          (cpu_emu_ff & ~cpu_err_clear);
         cpu_emulation_reset_override_flag_ff <= cpu_emu_rst_override |
                          (cpu_emulation_reset_override_flag_ff & ~cpu_err_clear);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dom_override_irq <= 2'b00;
         cpu_override_irq <= 1'b0;
      end else begin
         dom_override_irq <= dom_emu_ff & irq_en_ff;
         cpu_override_irq <=
            (cpu_emu_ff & emulation_override_irq_enable) |
            (cpu_emulation_reset_override_flag_ff & emulation_reset_override_irq_enable);
      end
   end

   // ==========================================================
   // read data
   logic [1:0]  busy;
   logic [31:0] rd_mux;
   logic [4:0]  mod_idx;

   assign busy    = {(seq_ff != pdsc_pkg::SQ_IDLE) | module_busy[1],
                     module_busy[0]};
   assign mod_idx = addr[6:2];

   function automatic logic [31:0] dom_stat(input logic       emu,
                                            input logic       done,
                                            input logic       por_n,
                                            input logic [4:0] st);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[pdsc_pkg::STAT_EMU_BIT]     = emu;
      v[pdsc_pkg::STAT_DOMAIN_POR_COMPLETE_BIT] = done;
      v[pdsc_pkg::STAT_POR_BIT]     = por_n;
      v[4:0]                        = st;
      return v;
   endfunction

   function automatic logic [31:0] dom_ctl(input logic [7:0] wk,
                                           input logic [3:0] md,
                                           input logic       ie,
                                           input logic       nx);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[pdsc_pkg::CTL_WAKE_LSB +: 8] = wk;
      v[pdsc_pkg::CTL_MODE_LSB +: 4] = md;
      v[pdsc_pkg::CTL_IRQEN_BIT]     = ie;
      v[pdsc_pkg::CTL_ONE_BIT]       = 1'b1;
      v[0]                           = nx;
      return v;
   endfunction

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr == pdsc_pkg::GO_STAT_OFF) begin
         rd_mux[1:0] = busy;
      end else if (addr == pdsc_pkg::AON_STAT_OFF) begin
         rd_mux = dom_stat(dom_emu_ff[0], por_done_s[0], por_n_s[0],
                           pdsc_pkg::DOM_ON);
      end else if (addr == pdsc_pkg::SW_STAT_OFF) begin
         rd_mux = dom_stat(dom_emu_ff[1], por_done_s[1], por_n_s[1],
                           dom_state_ff);
      end else if (addr == pdsc_pkg::AON_CTL_OFF) begin
         rd_mux = dom_ctl(wake_ff[0], pdsc_pkg::MODE_ALL_ON,
                          irq_en_ff[0], next_ff[0]);
      end else if (addr == pdsc_pkg::SW_CTL_OFF) begin
         rd_mux = dom_ctl(wake_ff[1], sw_mode_ff, irq_en_ff[1], next_ff[1]);
      end else if (addr == pdsc_pkg::AON_CFG_OFF) begin
         rd_mux[pdsc_pkg::CFG_TAP_BIT] = AON_HAS_TAP;
         rd_mux[pdsc_pkg::CFG_AON_BIT] = 1'b1;
      end else if (addr == pdsc_pkg::SW_CFG_OFF) begin
         rd_mux[pdsc_pkg::CFG_LOCK_BIT] = SW_LOCKED;
         rd_mux[pdsc_pkg::CFG_TAP_BIT]  = SW_HAS_TAP;
         rd_mux[pdsc_pkg::CFG_RAM_BIT]  = SW_IS_RAM;
      end else if (is_mapped(addr) && addr >= pdsc_pkg::MOD_STAT_BASE &&
                   int'(mod_idx) < NUM_MODULES) begin
         rd_mux[pdsc_pkg::MOD_CLK_BIT] = clk_run_s[mod_idx];
         rd_mux[5:0] = module_state[int'(mod_idx)*6 +: 6];
         if (int'(mod_idx) == pdsc_pkg::CPU_MODULE_IDX) begin
            rd_mux[pdsc_pkg::MOD_EMU_BIT]    = cpu_emu_ff;
            rd_mux[pdsc_pkg::MOD_EMULATION_RESET_OVERRIDE_FLAG_BIT] = cpu_emulation_reset_override_flag_ff;
         end
      end
   end

   // read data and error are captured in the setup cycle so both are
   // flip-flop outputs during the single access cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= ~is_mapped(addr);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_go_down;
      go_sw && seq_ff == pdsc_pkg::SQ_IDLE && sw_power_on && !next_ff[1];
   endsequence

   go_down_seq_a: assert property (s_go_down |=>
      dom_state_ff == pdsc_pkg::DOM_TR_DOWN [*4] ##1
      dom_state_ff == pdsc_pkg::DOM_OFF && !sw_power_on)
      else $error("power-down sequence timing wrong");

   trans_code_a: assert property (seq_ff != pdsc_pkg::SQ_IDLE |->
      dom_state_ff >= 5'h10 && dom_state_ff <= 5'h1a)
      else $error("transition code out of range");

   busy_track_a: assert property (setup_ph && !pwrite &&
      addr == pdsc_pkg::GO_STAT_OFF && seq_ff != pdsc_pkg::SQ_IDLE |=>
      prdata[1])
      else $error("busy low while sequencing");

   go_zero_a: assert property (
      wr_hit(addr, pdsc_pkg::GO_CMD_OFF, wr_acc) && !pwdata[1] &&
      seq_ff == pdsc_pkg::SQ_IDLE |=> seq_ff == pdsc_pkg::SQ_IDLE)
      else $error("go write of zero started a sequence");

   emu_sticky_a: assert property (dom_emu_override[1] |=>
      dom_emu_ff[1])
      else $error("override flag lost");

   emu_hold_a: assert property (dom_emu_ff[1] && !dom_err_clear[1]
      |=> dom_emu_ff[1])
      else $error("override flag dropped without clear");

   irq_gate_a: assert property (!irq_en_ff[1] |=>
      !dom_override_irq[1])
      else $error("domain irq raised while disabled");

   lock_next_a: assert property (
      wr_hit(addr, pdsc_pkg::SW_CTL_OFF, wr_acc) |=>
      next_ff[1] == (SW_LOCKED ? $past(next_ff[1]) : $past(pwdata[0])))
      else $error("next state write handling wrong");

   ctl_reset_a: assert property ($rose(!srst) |->
      wake_ff[1] == pdsc_pkg::WAKE_RST && sw_mode_ff == pdsc_pkg::MODE_ALL_ON)
      else $error("control reset values wrong");

   read_one_a: assert property (setup_ph && !pwrite &&
      addr == pdsc_pkg::SW_CTL_OFF |=> prdata[pdsc_pkg::CTL_ONE_BIT])
      else $error("control bit 8 not read as one");

   cpu_flag_a: assert property (cpu_emu_override |=> cpu_emu_ff)
      else $error("module 14 override flag lost");
endmodule

/* pdsc_far_model.sv */
// far-side model: gated domains and modules behind the power controller
`timescale 1ns/1ps
module pdsc_far_model (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         sw_power_on,
   input  wire logic [1:0]   module_go,
   output logic [1:0]        dom_por_n,
   output logic [1:0]        dom_por_done,
   output logic [31:0]       module_clock_running,
   output logic [191:0]      module_state,
   output logic [1:0]        module_busy
);
   // ==========================================================
   // domain power and module behaviour
   logic [3:0] busy_ff;
   // the switched domain reset follows its supply; done lags by a cycle
   assign dom_por_n = {sw_power_on, 1'b1};
   always_ff @(posedge sys_clk) begin
      dom_por_done <= srst ? 2'h0 : dom_por_n;
   end
   // upper modules sit in the switched domain and lose clock with it
   assign module_clock_running = {{16{sw_power_on}}, 16'hffff};
   assign module_state = {32{6'h03}};
   // each go keeps the domain's modules busy for two cycles
   always_ff @(posedge sys_clk) begin
      busy_ff <= srst ? 4'h0 : {busy_ff[1:0], module_go};
   end
   assign module_busy = busy_ff[1:0] | busy_ff[3:2];
endmodule

/* tb.sv */
// self-checking bench of the power domain status and control block
`timescale 1ns/1ps
module tb;
   logic          sys_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [31:0]   paddr, pwdata, prdata, module_clock_running;
   logic [1:0]    dom_por_n, dom_por_done, dom_emu_override, dom_err_clear;
   logic          cpu_emu_override, cpu_emu_rst_override, cpu_err_clear;
   logic          irq_en, rst_irq_en, sw_power_on, cpu_override_irq;
   logic [191:0]  module_state;
   logic [1:0]    module_busy, module_go, dom_override_irq;
   logic [3:0]    power_down_mode;
   logic [32:0]   exp_q [$];
   logic [7:0]    rnd;
   logic [3:0]    modes [7] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'ha, 4'hb, 4'hf};
   int            fails, checks_done, cycles;
   pdsc_ctrl dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dom_por_n(dom_por_n), .dom_por_done(dom_por_done),
      .dom_emu_override(dom_emu_override), .dom_err_clear(dom_err_clear),
      .cpu_emu_override(cpu_emu_override),
      .cpu_emu_rst_override(cpu_emu_rst_override),
      .cpu_err_clear(cpu_err_clear),
      .emulation_override_irq_enable(irq_en),
      .emulation_reset_override_irq_enable(rst_irq_en),
      .module_clock_running(module_clock_running),
      .module_state(module_state), .module_busy(module_busy),
      .module_go(module_go), .sw_power_on(sw_power_on),
      .power_down_mode(power_down_mode),
      .dom_override_irq(dom_override_irq),
      .cpu_override_irq(cpu_override_irq));
   pdsc_far_model far (.sys_clk(sys_clk), .srst(srst),
      .sw_power_on(sw_power_on), .module_go(module_go),
      .dom_por_n(dom_por_n), .dom_por_done(dom_por_done),
      .module_clock_running(module_clock_running),
      .module_state(module_state), .module_busy(module_busy));
   // ==========================================================
   // clock, checking and closing
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wrap_up;
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("unexpected read {err,data} exp %h got %h", e, s);
      end
   endtask
   task automatic cmp_out(input string n, input logic [3:0] e,
                          input logic [3:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   // read results are matched against the oldest note at the access edge
   always @(posedge sys_clk) begin
      cycles++;
      if (psel && penable && pready && !pwrite)
         cmp_rd(exp_q.pop_front(), {pslverr, prdata});
      if (cycles == 6000) begin
         fails++;
         wrap_up();
      end
   end
   // ==========================================================
   // bus and stimulus tasks
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= d;
      if (!w)
         exp_q.push_back(e);
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // ==========================================================
   // scenarios
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {dom_emu_override, dom_err_clear, cpu_err_clear} = '0;
      {cpu_emu_override, cpu_emu_rst_override} = '0;
      irq_en = 1'b1;
      rst_irq_en = 1'b1;
      srst = 1'b1;
      rnd = 8'h62;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      idle(3);
      rd(pdsc_pkg::SW_CTL_OFF, 33'h001f_f101);
      rd(pdsc_pkg::AON_CFG_OFF, 33'h1);
      rd(pdsc_pkg::SW_CFG_OFF, 33'h2);
      wr(pdsc_pkg::AON_CFG_OFF, 32'hffff_ffff);
      rd(pdsc_pkg::AON_CFG_OFF, 33'h1);
      rd(pdsc_pkg::AON_STAT_OFF, 33'h301);
      rd(12'h0fc, {1'b1, 32'h0});
      wr(pdsc_pkg::AON_CTL_OFF, 32'h0);
      rd(pdsc_pkg::AON_CTL_OFF, 33'h0000_f100);
      wr(pdsc_pkg::GO_CMD_OFF, 32'h1);
      @(posedge sys_clk) cmp_out("go", 4'h1, {2'h0, module_go});
      idle(5);
      rd(pdsc_pkg::AON_STAT_OFF, 33'h301);
      foreach (modes[i]) begin
         rnd = lfsr(rnd);
         wr(pdsc_pkg::SW_CTL_OFF, {8'hff, rnd, modes[i], 12'h201});
         rd(pdsc_pkg::SW_CTL_OFF, {9'h0, rnd, modes[i], 12'h301});
      end
      wr(pdsc_pkg::SW_CTL_OFF, 32'h0023_a200);
      idle(2);
      cmp_out("mode", 4'ha, power_down_mode);
      wr(pdsc_pkg::GO_CMD_OFF, 32'h0);
      rd(pdsc_pkg::SW_STAT_OFF, 33'h301);
      wr(pdsc_pkg::GO_CMD_OFF, 32'h2);
      rd(pdsc_pkg::SW_STAT_OFF, 33'h310);
      idle(12);
      rd(pdsc_pkg::SW_STAT_OFF, 33'h0);
      rd(pdsc_pkg::GO_STAT_OFF, 33'h0);
      rd(pdsc_pkg::MOD_STAT_BASE + 12'h050, 33'h0003);
      cmp_out("power", 4'h0, {3'h0, sw_power_on});
      wr(pdsc_pkg::SW_CTL_OFF, 32'h0023_a201);
      wr(pdsc_pkg::GO_CMD_OFF, 32'h2);
      @(posedge sys_clk) cmp_out("go", 4'h2, {2'h0, module_go});
      rd(pdsc_pkg::GO_STAT_OFF, 33'h2);
      idle(25);
      rd(pdsc_pkg::SW_STAT_OFF, 33'h301);
      cmp_out("power", 4'h1, {3'h0, sw_power_on});
      @(posedge sys_clk) dom_emu_override <= 2'b10;
      @(posedge sys_clk) dom_emu_override <= 2'b00;
      idle(3);
      cmp_out("dom irq", 4'h2, {2'h0, dom_override_irq});
      rd(pdsc_pkg::SW_STAT_OFF, 33'hb01);
      @(posedge sys_clk) dom_err_clear <= 2'b10;
      @(posedge sys_clk) dom_err_clear <= 2'b00;
      idle(3);
      rd(pdsc_pkg::SW_STAT_OFF, 33'h301);
      cmp_out("dom irq", 4'h0, {2'h0, dom_override_irq});
      @(posedge sys_clk) {cpu_emu_override, cpu_emu_rst_override} <= 2'b11;
      @(posedge sys_clk) {cpu_emu_override, cpu_emu_rst_override} <= 2'b00;
      idle(3);
      cmp_out("cpu irq", 4'h1, {3'h0, cpu_override_irq});
      rd(pdsc_pkg::MOD_STAT_BASE + 12'h038, 33'h3_1003);
      rd(pdsc_pkg::MOD_STAT_BASE + 12'h034, 33'h1003);
      rd(pdsc_pkg::MOD_STAT_BASE + 12'h050, 33'h1003);
      @(posedge sys_clk) cpu_err_clear <= 1'b1;
      @(posedge sys_clk) cpu_err_clear <= 1'b0;
      idle(3);
      rd(pdsc_pkg::MOD_STAT_BASE + 12'h038, 33'h1003);
      cmp_out("cpu irq", 4'h0, {3'h0, cpu_override_irq});
      idle(4);
      wrap_up();
   end
endmodule
